/* File: src/ddr_host.sv */
`timescale 1ns/1ps
`include "ddr_host_defines.svh"
// What this block does
// - Open a row with Active before any Read or Write to that bank.
// - Read or Write to an opened row only after tRCD.
// - Precharge before activating another row; Actives to one bank tRC apart.
// - Activating another bank while one is being accessed is allowed.
// - Reads may follow reads; spacing is at least BL/2 CK, whatever the desired data pairs.
// - Burst Terminate comes desired-pairs cycles after the Read.
// - Read burst completes or is terminated before a Write.
// - Precharge may follow or truncate a read without auto precharge.
// - No command to a precharged bank until tRP has passed.
// - Controller holds DQS low as write preamble and postamble.
// - First write DQS rise lies 75% to 125% of CK after Write.
// - Writes may follow writes; spacing is at least BL/2 + 2 CK, whatever the desired data pairs.
// - Write to Read without truncation observes tWTR.
// - A Read never truncates a write; it waits for the whole burst plus tWTR.
// - Write to Precharge observes tWR; truncated data is masked with DM.
// - A10 on Read or Write selects auto precharge for that command only.
module ddr_host
    import ddr_host_pkg::*;
#(
    parameter int CL_CK    = `CL_CK,
    parameter int T_RCD_NS = `T_RCD_NS,
    parameter int T_RP_NS  = `T_RP_NS,
    parameter int T_RC_NS  = `T_RC_NS,
    parameter int T_RAS_NS = `T_RAS_NS,
    parameter int T_WR_NS  = `T_WR_NS,
    parameter int T_WTR_NS = `T_WTR_NS
)
(
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 req_valid_in,
    input  wire ddr_host_pkg::req_s   req_in,
    output logic                      req_ready_out,
    output logic                      rd_valid_out,
    output logic [`DQ_W-1:0]          rd_data_out,
    output logic                      ck_out,
    output logic                      ck_n_out,
    output logic                      cke_out,
    output ddr_host_pkg::cmd_s        cmd_out,
    input  wire logic [`DQ_W-1:0]     dq_in,
    output logic [`DQ_W-1:0]          dq_out,
    output logic                      dq_oe_n_out,
    input  wire logic                 dqs_in,
    output logic                      dqs_out,
    output logic                      dqs_oe_n_out,
    output logic                      dm_out
);
    import ddr_host_pkg::*;

    localparam int CK_NS = `CLK_NS * `CK_DIV;

    function automatic logic [7:0] ck_of(input int ns);
        int c;
        c = (ns + CK_NS - 1) / CK_NS;
        return (c < 1) ? 8'h01 : 8'(c);
    endfunction

    localparam logic [7:0] BL2      = 8'(`BL / 2);
    localparam logic [7:0] RCD_CK   = ck_of(T_RCD_NS);
    localparam logic [7:0] RP_CK    = ck_of(T_RP_NS);
    localparam logic [7:0] RC_CK    = ck_of(T_RC_NS);
    localparam logic [7:0] RAS_CK   = ck_of(T_RAS_NS);
    localparam logic [7:0] WR_CK    = ck_of(T_WR_NS);
    localparam logic [7:0] WTR_CK   = ck_of(T_WTR_NS);
    localparam logic [7:0] RD2WR_CK = 8'(CL_CK) + BL2 + 8'h01;
    localparam logic [7:0] BST2WR   = 8'(CL_CK) + 8'h01;
    localparam logic [7:0] WR2RD_CK = 8'h01 + BL2 + WTR_CK;
    localparam logic [7:0] WR2WR_CK = BL2 + 8'h02;
    localparam logic [7:0] WR2PRE   = 8'h01 + BL2 + WR_CK;
    localparam logic [5:0] WR_END   = 6'(`WR_DQS_S + 2 * `BL + `WR_POST);
    localparam int K_ACT = 0;
    localparam int K_PRE = 1;
    localparam int K_RD  = 2;
    localparam int K_WR  = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Link clock: CK is clk_in divided by four; commands change at CK fall

    logic [1:0] phase;
    logic       tick;

    assign tick = (phase == `PH_TICK);

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            phase    <= 2'h0;
            ck_out   <= 1'b0;
            ck_n_out <= 1'b1;
            cke_out  <= 1'b0;
        end
        else
        begin
            phase    <= phase + 2'h1;
            ck_out   <= (phase == `PH_CK_HI0) || (phase == `PH_CK_HI1);
            ck_n_out <= !((phase == `PH_CK_HI0) || (phase == `PH_CK_HI1));
            cke_out  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command selection

    ctl_state_e           state;
    req_s                 req;
    logic [7:0]           trunc_cnt;
    logic [7:0]           rd_gap;
    logic [7:0]           wr_gap;
    logic [`BANKS-1:0]    bank_open;
    logic [`ROW_W-1:0]    bank_row  [`BANKS];
    logic [7:0]           ready_cnt [`BANKS];
    logic [7:0]           rc_cnt    [`BANKS];
    logic [7:0]           pre_cnt   [`BANKS];
    logic                 iss_act;
    logic                 iss_pre;
    logic                 iss_rd;
    logic                 iss_wr;
    logic                 iss_bst;
    logic [7:0]           rd_pairs;
    logic [7:0]           wr_pairs;
    cmd_s                 next_cmd;

    // Auto precharge reads cannot be terminated, so they always run full length
    assign rd_pairs = (req.pairs == '0 || req.auto_pre || 8'(req.pairs) > BL2) ?
                      BL2 : 8'(req.pairs);
    assign wr_pairs = (req.pairs == '0 || 8'(req.pairs) > BL2) ? BL2 : 8'(req.pairs);
    assign req_ready_out = tick && (state == ST_IDLE);

    always_comb
    begin
        iss_act = 1'b0;
        iss_pre = 1'b0;
        iss_rd  = 1'b0;
        iss_wr  = 1'b0;
        iss_bst = 1'b0;
        if (tick && state == ST_ISSUE && ready_cnt[req.bank] == 8'h00)
        begin
            if (bank_open[req.bank] && bank_row[req.bank] != req.row)
                iss_pre = (pre_cnt[req.bank] == 8'h00);
            else if (!bank_open[req.bank])
                iss_act = (rc_cnt[req.bank] == 8'h00);
            else if (req.write)
                iss_wr = (wr_gap == 8'h00);
            else
                iss_rd = (rd_gap == 8'h00);
        end
        if (tick && state == ST_TRUNC && trunc_cnt == 8'h00)
            iss_bst = 1'b1;
        next_cmd.code = `CMD_NOP;
        next_cmd.ba   = req.bank;
        next_cmd.addr = '0;
        if (iss_act)
        begin
            next_cmd.code = `CMD_ACT;
            next_cmd.addr = req.row;
        end
        else if (iss_pre)
            next_cmd.code = `CMD_PRE;
        else if (iss_rd || iss_wr)
        begin
            next_cmd.code = iss_wr ? `CMD_WR : `CMD_RD;
            next_cmd.addr = req.col;
            next_cmd.addr[`AP_BIT] = req.auto_pre;
        end
        else if (iss_bst)
            next_cmd.code = `CMD_BST;
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            state     <= ST_IDLE;
            req       <= '0;
            trunc_cnt <= 8'h00;
            cmd_out   <= '{code: `CMD_DESEL, ba: '0, addr: '0};
        end
        else if (tick)
        begin
            cmd_out <= next_cmd;
            case (state)
                ST_IDLE:
                begin
                    if (req_valid_in)
                    begin
                        req   <= req_in;
                        state <= ST_ISSUE;
                    end
                end
                ST_ISSUE:
                begin
                    if (iss_rd && rd_pairs != BL2)
                    begin
                        state     <= ST_TRUNC;
                        trunc_cnt <= rd_pairs - 8'h01;
                    end
                    else if (iss_rd || iss_wr)
                        state <= ST_IDLE;
                end
                ST_TRUNC:
                begin
                    if (iss_bst)
                        state <= ST_IDLE;
                    else
                        trunc_cnt <= trunc_cnt - 8'h01;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data bus turnaround timers, counted in CK cycles

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            rd_gap <= 8'h00;
            wr_gap <= 8'h00;
        end
        else if (iss_rd)
        begin
            rd_gap <= BL2 - 8'h01;
            wr_gap <= RD2WR_CK - 8'h01;
        end
        else if (iss_bst)
            wr_gap <= BST2WR - 8'h01;
        else if (iss_wr)
        begin
            rd_gap <= WR2RD_CK - 8'h01;
            wr_gap <= WR2WR_CK - 8'h01;
        end
        else if (tick)
        begin
            rd_gap <= (rd_gap == 8'h00) ? 8'h00 : rd_gap - 8'h01;
            wr_gap <= (wr_gap == 8'h00) ? 8'h00 : wr_gap - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-bank state; other banks run their own timers while one is busy

    for (genvar b = 0; b < `BANKS; b++)
    begin : g_bank
        logic sel;
        assign sel = (req.bank == `BA_W'(b));
        always_ff @(posedge clk_in)
        begin
            if (!reset_n_in)
            begin
                bank_open[b] <= 1'b0;
                bank_row[b]  <= '0;
                ready_cnt[b] <= 8'h00;
                rc_cnt[b]    <= 8'h00;
                pre_cnt[b]   <= 8'h00;
            end
            else if (sel && iss_act)
            begin
                bank_open[b] <= 1'b1;
                bank_row[b]  <= req.row;
                ready_cnt[b] <= RCD_CK - 8'h01;
                rc_cnt[b]    <= RC_CK - 8'h01;
                pre_cnt[b]   <= RAS_CK - 8'h01;
            end
            else if (sel && iss_pre)
            begin
                bank_open[b] <= 1'b0;
                ready_cnt[b] <= RP_CK - 8'h01;
            end
            else if (sel && iss_rd && req.auto_pre)
            begin
                bank_open[b] <= 1'b0;
                ready_cnt[b] <= BL2 + RP_CK - 8'h01 + pre_cnt[b];
            end
            else if (sel && iss_wr && req.auto_pre)
            begin
                bank_open[b] <= 1'b0;
                ready_cnt[b] <= WR2PRE + RP_CK - 8'h01;
            end
            else if (sel && iss_wr)
                pre_cnt[b] <= (pre_cnt[b] > WR2PRE) ? pre_cnt[b] : WR2PRE - 8'h01;
            else if (tick)
            begin
                ready_cnt[b] <= (ready_cnt[b] == 8'h00) ? 8'h00 : ready_cnt[b] - 8'h01;
                rc_cnt[b]    <= (rc_cnt[b] == 8'h00) ? 8'h00 : rc_cnt[b] - 8'h01;
                pre_cnt[b]   <= (pre_cnt[b] == 8'h00) ? 8'h00 : pre_cnt[b] - 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write burst: DQS edges centred in each data element

    logic                   wr_act;
    logic [5:0]             wcnt;
    logic [5:0]             ws;
    logic [5:0]             wel;
    logic [`BL*`DQ_W-1:0]   wbuf;
    logic [`BL-1:0]         wmask;
    logic [7:0]             wpairs;

    assign ws  = wcnt + 6'h01;
    assign wel = (ws - 6'(`WR_DQ_S)) >> 1;

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            wr_act <= 1'b0;
            wcnt   <= 6'h00;
            wbuf   <= '0;
            wmask  <= '0;
            wpairs <= 8'h00;
        end
        else if (iss_wr)
        begin
            wr_act <= 1'b1;
            wcnt   <= 6'h00;
            wbuf   <= req.wdata;
            wmask  <= req.wmask;
            wpairs <= wr_pairs;
        end
        else if (wr_act)
        begin
            wcnt   <= wcnt + 6'h01;
            wr_act <= (ws != WR_END);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            dq_out       <= '0;
            dq_oe_n_out  <= 1'b1;
            dqs_out      <= 1'b0;
            dqs_oe_n_out <= 1'b1;
            dm_out       <= 1'b1;
        end
        else
        begin
            dqs_oe_n_out <= !(wr_act && ws >= 6'(`WR_OE_S) && ws < WR_END);
            // first rise one CK after Write
            dqs_out <= wr_act && ws >= 6'(`WR_DQS_S) && ws < 6'(`WR_DQS_S + 2 * `BL)
                       && ws[1];
            dq_oe_n_out <= !(wr_act && ws >= 6'(`WR_DQ_S) && ws < 6'(`WR_DQ_S + 2 * `BL));
            if (wr_act && ws >= 6'(`WR_DQ_S) && ws < 6'(`WR_DQ_S + 2 * `BL))
            begin
                dq_out <= wbuf[wel[1:0] * `DQ_W +: `DQ_W];
                dm_out <= wmask[wel[1:0]] || (8'(wel) >= {wpairs[6:0], 1'b0});
            end
            else
                dm_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read capture; pins are synchronised before any logic looks at them

    logic [`DQ_W-1:0] dq_s1;
    logic [`DQ_W-1:0] dq_s2;
    logic             dqs_s1;
    logic             dqs_s2;
    logic             dqs_prev;
    logic [31:0]      rd_win;
    logic [31:0]      rd_new;
    logic             rd_take;

    // Element slots follow from CL and the fixed CK phase; a released strobe has
    // no known idle level, so only changes inside a slot count
    always_comb
    begin
        rd_new = '0;
        for (int j = 0; j < `BL; j++)
            if (iss_rd && j < 2 * int'(rd_pairs))
                rd_new[4 + 4 * CL_CK + 2 * j] = 1'b1;
    end

    // preamble or odd element is low, so every slot holds a strobe change
    assign rd_take = rd_win[0] && (dqs_s2 != dqs_prev);

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            dq_s1    <= '0;
            dq_s2    <= '0;
            dqs_s1   <= 1'b0;
            dqs_s2   <= 1'b0;
            dqs_prev <= 1'b0;
        end
        else
        begin
            dq_s1    <= dq_in;
            dq_s2    <= dq_s1;
            dqs_s1   <= dqs_in;
            dqs_s2   <= dqs_s1;
            dqs_prev <= dqs_s2;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            rd_win       <= '0;
            rd_valid_out <= 1'b0;
            rd_data_out  <= '0;
        end
        else
        begin
            rd_win <= (rd_win >> 1) | rd_new;
            rd_valid_out <= rd_take;
            if (rd_take)
                rd_data_out <= dq_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [3:0] kind_iss;
    logic [7:0] since [4];
    logic [1:0] hbank [4];
    logic       wr_shown;
    logic       rw_shown;

    assign kind_iss = {iss_wr, iss_rd, iss_pre, iss_act};
    assign wr_shown = (phase == `PH_SHOWN) && (cmd_out.code == `CMD_WR);
    assign rw_shown = wr_shown || ((phase == `PH_SHOWN) && (cmd_out.code == `CMD_RD));

    for (genvar k = 0; k < 4; k++)
    begin : g_since
        always_ff @(posedge clk_in)
        begin
            if (!reset_n_in)
            begin
                since[k] <= 8'hFF;
                hbank[k] <= '0;
            end
            else if (kind_iss[k])
            begin
                since[k] <= 8'h01;
                hbank[k] <= req.bank;
            end
            else if (tick && since[k] != 8'hFF)
                since[k] <= since[k] + 8'h01;
        end
    end

    sequence s_preamble;
        (!dqs_oe_n_out && !dqs_out) [*2];
    endsequence

    sequence s_first_rise;
        $rose(dqs_out) && $rose(ck_out);
    endsequence

    a_act_before_rw: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (iss_rd || iss_wr) |-> bank_open[req.bank] && since[K_ACT] != 8'hFF)
        else $error("access to a bank with no open row");
    a_rcd_spacing: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (iss_rd || iss_wr) && req.bank == hbank[K_ACT] |-> since[K_ACT] >= RCD_CK)
        else $error("read or write before tRCD");
    a_act_closed: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        iss_act |-> !bank_open[req.bank])
        else $error("activate to a bank with an open row");
    a_rc_spacing: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        iss_act && req.bank == hbank[K_ACT] |-> since[K_ACT] >= RC_CK)
        else $error("activates to one bank closer than tRC");
    a_rp_spacing: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (iss_act || iss_rd || iss_wr) && req.bank == hbank[K_PRE] |-> since[K_PRE] >= RP_CK)
        else $error("command to bank before tRP");
    a_bst_timing: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        iss_bst |-> since[K_RD] == rd_pairs)
        else $error("burst terminate not at desired pairs");
    a_wtr_spacing: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        iss_rd |-> since[K_WR] >= WR2RD_CK)
        else $error("read too soon after write");
    a_wr_preamble: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_shown |-> ##4 s_preamble ##1 dqs_out)
        else $error("write preamble not held low");
    a_wr_dqss: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_shown |-> ##6 s_first_rise)
        else $error("first write strobe not one clock after write");
    a_ap_a10: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        rw_shown |-> cmd_out.addr[`AP_BIT] == req.auto_pre)
        else $error("A10 does not match auto precharge request");

endmodule

/* File: include/ddr_host_defines.svh */
`ifndef DDR_HOST_DEFINES_SVH
`define DDR_HOST_DEFINES_SVH

// Widths
`define DQ_W        8
`define BL          4
`define PAIR_W      2
`define BANKS       4
`define BA_W        2
`define ROW_W       14
`define AP_BIT      10

// System clock and link clock divider
`define CLK_NS      5
`define CK_DIV      4
`define PH_TICK     2'h2
`define PH_SHOWN    2'h3
`define PH_CK_HI0   2'h0
`define PH_CK_HI1   2'h1

// Default device timing (ns) and read latency (CK cycles)
`define CL_CK       2
`define T_RCD_NS    15
`define T_RP_NS     15
`define T_RC_NS     55
`define T_RAS_NS    40
`define T_WR_NS     15
`define T_WTR_NS    10

// Write burst pin timing, in system cycles after the command shows
`define WR_OE_S     4
`define WR_DQ_S     5
`define WR_DQS_S    6
`define WR_POST     2

// Command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_DESEL   4'hF
`define CMD_NOP     4'h7
`define CMD_ACT     4'h3
`define CMD_RD      4'h5
`define CMD_WR      4'h4
`define CMD_BST     4'h6
`define CMD_PRE     4'h2

`endif

/* File: include/ddr_host_pkg.sv */
`include "ddr_host_defines.svh"

package ddr_host_pkg;

    typedef struct packed {
        logic                     write;
        logic                     auto_pre;
        logic [`BA_W-1:0]         bank;
        logic [`ROW_W-1:0]        row;
        logic [`ROW_W-1:0]        col;
        logic [`PAIR_W-1:0]       pairs;
        logic [`BL-1:0]           wmask;
        logic [`BL*`DQ_W-1:0]     wdata;
    } req_s;

    typedef struct packed {
        logic [3:0]               code;
        logic [`BA_W-1:0]         ba;
        logic [`ROW_W-1:0]        addr;
    } cmd_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_TRUNC
    } ctl_state_e;

endpackage

/* File: tb/ddr_dev_model.sv */
`timescale 1ns/1ps
`include "ddr_host_defines.svh"
module ddr_dev_model
    import ddr_host_pkg::*;
#(
    parameter int CL_CK = `CL_CK
)
(
    input  wire logic               ck_in,
    input  wire logic               cke_in,
    input  wire ddr_host_pkg::cmd_s cmd_in,
    input  wire logic [`DQ_W-1:0]   dq_in,
    input  wire logic               dqs_in,
    input  wire logic               dqs_oe_n_in,
    input  wire logic               dm_in,
    output logic [`DQ_W-1:0]        dq_out,
    output logic                    dqs_out,
    output int                      viol_out
);
    import ddr_host_pkg::*;
    localparam real CK = `CLK_NS * `CK_DIV;
    logic [`DQ_W-1:0] mem [logic [25:0]];
    logic             open_q [`BANKS];
    logic [13:0]      row_q [`BANKS];
    logic [`DQ_W:0]   slot [int];
    realtime          t_act [`BANKS];
    realtime          t_pre [`BANKS];
    realtime          t_wr;
    int               hc = 0;
    int               rd_hc = 0;
    int               wr_idx = `BL;
    logic [25:0]      rd_key;
    logic [25:0]      wr_key;
    logic [25:0]      a;
    logic             drv = 0;
    initial
    begin
        dq_out = '0;
        dqs_out = 1'b0;
        viol_out = 0;
        foreach (open_q[i])
        begin
            open_q[i] = 1'b0;
            row_q[i] = '0;
            t_act[i] = -1.0e4;
            t_pre[i] = -1.0e4;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////
    always @(posedge ck_in or negedge ck_in)
    begin
        hc = hc + 1;
        if (ck_in && cke_in)
        begin
            a = {cmd_in.ba, row_q[cmd_in.ba], cmd_in.addr[9:0]};
            case (cmd_in.code)
                `CMD_ACT: begin
                    if (open_q[cmd_in.ba] || $realtime - t_pre[cmd_in.ba] < `T_RP_NS
                        || $realtime - t_act[cmd_in.ba] < `T_RC_NS)
                        viol_out++;
                    open_q[cmd_in.ba] = 1'b1;
                    t_act[cmd_in.ba] = $realtime;
                    row_q[cmd_in.ba] = cmd_in.addr;
                end
                `CMD_RD, `CMD_WR: begin
                    if (!open_q[cmd_in.ba] || $realtime - t_act[cmd_in.ba] < `T_RCD_NS)
                        viol_out++;
                    if (cmd_in.code == `CMD_RD)
                    begin
                        rd_hc = hc;
                        for (int j = 0; j < `BL; j++)
                        begin
                            rd_key = {a[25:2], a[1:0] + 2'(j)};
                            slot[hc + 2 * CL_CK + j] = {!j[0], mem.exists(rd_key) ? mem[rd_key] : '0};
                        end
                        if (!slot.exists(hc + 2 * CL_CK - 1))
                            slot[hc + 2 * CL_CK - 1] = '0;
                    end
                    else
                    begin
                        wr_idx = 0;
                        t_wr = $realtime;
                        wr_key = a;
                    end
                    if (cmd_in.addr[`AP_BIT])
                    begin
                        open_q[cmd_in.ba] = 1'b0;
                        t_pre[cmd_in.ba] = (cmd_in.code == `CMD_WR)
                            ? $realtime + (1 + `BL / 2) * CK + `T_WR_NS
                            : (t_act[cmd_in.ba] + `T_RAS_NS > $realtime + `BL / 2 * CK)
                            ? t_act[cmd_in.ba] + `T_RAS_NS : $realtime + `BL / 2 * CK;
                    end
                end
                `CMD_PRE: begin
                    open_q[cmd_in.ba] = 1'b0;
                    t_pre[cmd_in.ba] = $realtime;
                end
                `CMD_BST:
                    for (int j = hc - rd_hc; j < `BL; j++)
                        slot.delete(rd_hc + 2 * CL_CK + j);
                default: ;
            endcase
        end
        // read data and strobe; a released bus shows the inverse
        if (slot.exists(hc))
        begin
            drv = 1'b1;
            {dqs_out, dq_out} = slot[hc];
            slot.delete(hc);
        end
        else if (drv)
        begin
            drv = 1'b0;
            dqs_out = !dqs_out;
            dq_out = ~dq_out;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////
    // write capture
    always @(posedge dqs_in or negedge dqs_in)
        if (dqs_oe_n_in === 1'b0 && wr_idx < `BL && (wr_idx > 0 || dqs_in))
        begin
            if (wr_idx == 0 && ($realtime - t_wr < 0.75 * CK || $realtime - t_wr > 1.25 * CK))
                viol_out++;
            if (dm_in === 1'b0)
                mem[{wr_key[25:2], wr_key[1:0] + 2'(wr_idx)}] = dq_in;
            wr_idx++;
        end
endmodule

/* File: tb/ddr_host_tb_top.sv */
`timescale 1ns/1ps
`include "ddr_host_defines.svh"
module ddr_host_tb_top;
    import ddr_host_pkg::*;
    logic             clk_in = 0;
    logic             reset_n_in = 0;
    logic             req_valid_in = 0;
    req_s             req_in = '0;
    req_s             r;
    cmd_s             cmd_out;
    logic             req_ready_out, rd_valid_out, ck_out, ck_n_out, cke_out;
    logic             dq_oe_n_out, dqs_out, dqs_oe_n_out, dm_out, dev_dqs;
    logic [`DQ_W-1:0] rd_data_out, dq_out, dev_dq;
    wire  [`DQ_W-1:0] dq_in = (dq_oe_n_out === 1'b0) ? dq_out : dev_dq;
    wire              dqs_in = (dqs_oe_n_out === 1'b0) ? dqs_out : dev_dqs;
    int               fail_count = 0, num_checks = 0, seed = 60179, viol, n;
    logic [31:0]      rnd;
    logic [`DQ_W-1:0] ref_mem [logic [25:0]];
    logic [`DQ_W-1:0] exp_q [$];
    logic [25:0]      key;
    ddr_host ddr_host_i (.clk_in, .reset_n_in, .req_valid_in, .req_in, .req_ready_out,
        .rd_valid_out, .rd_data_out, .ck_out, .ck_n_out, .cke_out, .cmd_out, .dq_in, .dq_out,
        .dq_oe_n_out, .dqs_in, .dqs_out, .dqs_oe_n_out, .dm_out);
    ddr_dev_model ddr_dev_model_i (.ck_in(ck_out), .cke_in(cke_out), .cmd_in(cmd_out),
        .dq_in(dq_out), .dqs_in(dqs_out), .dqs_oe_n_in(dqs_oe_n_out), .dm_in(dm_out),
        .dq_out(dev_dq), .dqs_out(dev_dqs), .viol_out(viol));
    initial
    begin
        forever #2.5 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic chk_data(input logic [`DQ_W-1:0] got, input logic [`DQ_W-1:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_count(input int got, input int exp);
        num_checks++;
        if (got != exp)
        begin
            fail_count++;
            $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in)
        if (rd_valid_out === 1'b1)
        begin
            if (exp_q.size() > 0)
                chk_data(rd_data_out, exp_q.pop_front());
            else
                chk_count(1, 0);
        end
    task automatic send(input req_s q);
        @(posedge clk_in);
        #1;
        req_in = q;
        req_valid_in = 1'b1;
        n = 0;
        do
            @(posedge clk_in);
        while (req_ready_out !== 1'b1 && ++n < 2000);
        #1;
        req_valid_in = 1'b0;
        chk_count(n < 2000, 1);
        for (int j = 0; j < `BL; j++)
        begin
            key = {q.bank, q.row, q.col[9:2], q.col[1:0] + 2'(j)};
            if (q.write && !q.wmask[j] && (q.pairs == 0 || 2 * q.pairs > j))
                ref_mem[key] = q.wdata[8*j+:8];
            else if (!q.write && (q.auto_pre || q.pairs == 0 || q.pairs > 2 || 2 * q.pairs > j))
                exp_q.push_back(ref_mem.exists(key) ? ref_mem[key] : '0);
        end
    endtask
    initial
    begin
        #200000;
        fail_count++;
        $display("wrong value at %0t: timeout", $time);
        summarize();
    end
    initial
    begin
        repeat (5) @(posedge clk_in);
        #1;
        reset_n_in = 1'b1;
        for (int i = 0; i < 80; i++)
        begin
            rnd = $random(seed);
            r.write = rnd[0];
            r.auto_pre = rnd[2:1] == 2'h0;
            r.bank = rnd[4:3];
            r.row = {13'h0, rnd[5]};
            r.col = {11'h0, rnd[6], 2'h0};
            r.pairs = r.auto_pre ? 2'h0 : rnd[8:7];
            r.wmask = rnd[12:9];
            r.wdata = $random(seed);
            send(r);
        end
        n = 0;
        while (exp_q.size() > 0 && n < 2000)
        begin
            @(posedge clk_in);
            n++;
        end
        repeat (40) @(posedge clk_in);
        chk_count(exp_q.size(), 0);
        chk_count(viol, 0);
        summarize();
    end
endmodule
